// *** rtl/flnvc_boot_config.sv ***
// Behaviour
// R1: boot register changed by 01h or 71h after 06h; read with 65h.
// R2: bit 7 enables io3 as reset when cs high, quad off or wide off.
// R3: io3 reset enable loaded from bit 7 after every reset.
// R4: bits 6:5 drive strength, 00 strongest, 11 weakest, default 11.
// R5: bit 3 boots four-wide instruction mode; default serial.
// R6: instruction width loaded from bit 3 on every reset.
// R7: host enters wide mode with 38h or a volatile register write.
// R8: volatile width change takes effect at frame end; next frame uses it.
// R9: host programs bit 3 with 71h then polls status busy bit 0.
// R10: host leaves wide mode with F5h or a volatile register write.
// R11: bit 2 selects protection method after reset: 0 legacy, 1 block lock.
// R12: protection method loaded from bit 2 on every reset.
// R13: bit 1 selects 3-byte (0) or 4-byte (1) addressing after reset.
// R14: address length applies to variable-length address commands; 4-byte means 32 bits.
// R15: bits 4 and 0 reserved, read 0.
// R16: programming boot bit 1 also updates live address length bit.
// R17: while programming, busy stays set and register writes are ignored.
`timescale 1ns/10ps
`default_nettype none
module flnvc_boot_config #(
    parameter int PROG_CYCLES = flnvc_pkg::PROG_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // serial link pins
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic [3:0] i_io,
    output logic [3:0] o_io,
    output logic [3:0] o_io_oe,
    // context from other configuration
    input wire logic i_quad_mode,
    // working configuration
    output logic o_io3_reset_enable,
    output logic [1:0] o_drive_strength,
    output logic o_four_wide_instruction_mode,
    output logic o_protect_method,
    output logic o_address_four_byte,
    output logic o_busy,
    output logic [7:0] o_boot_interface_config
);
    typedef struct packed {
        flnvc_pkg::flnvc_phase_type phase;
        logic [5:0] cnt;
        logic [31:0] sh;
        logic [7:0] cmd;
        logic [23:0] addr;
        logic [1:0] nbytes;
        logic got;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [3:0] out;
        logic [3:0] oe;
        logic wel;
        logic wvel;
        logic rst_en;
        logic busy;
        logic [15:0] prog_cnt;
        logic [7:0] pend;
        logic [7:0] boot;
        logic [7:0] live;
        logic sclk_prev;
        logic cs_prev;
        logic [3:0] drv_hist;
    } flnvc_state_type;

    function automatic logic [7:0] load_live(input logic [7:0] boot);
        logic [7:0] v;
        v = boot & flnvc_pkg::BOOT_CONFIG_WRITABLE;
        v[flnvc_pkg::BIT_ADDRESS_LIVE] = boot[flnvc_pkg::BIT_ADDRESS_BOOT]; // R13
        return v;
    endfunction

    localparam flnvc_state_type ST_RESET = '{
        phase: flnvc_pkg::PH_IDLE, cnt: 6'h00, sh: 32'h0, cmd: 8'h00, addr: 24'h0,
        nbytes: 2'h0, got: 1'b0, wdata: 8'h00, rdata: 8'h00, out: 4'h0, oe: 4'h0,
        wel: 1'b0, wvel: 1'b0, rst_en: 1'b0, busy: 1'b0, prog_cnt: 16'h0000, drv_hist: 4'h0,
        pend: 8'h00, boot: flnvc_pkg::BOOT_CONFIG_RESET,
        live: load_live(flnvc_pkg::BOOT_CONFIG_RESET), sclk_prev: 1'b0, cs_prev: 1'b1};

    flnvc_state_type state_ff;
    flnvc_state_type nxt_state;
    logic [5:0] pins;

    flnvc_pin_sync #(.W(6), .RST_VAL(6'h1F)) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async({i_sclk, i_cs_n, i_io}),
        .o_level(pins)
    );

    always_comb begin
        logic sclk_s;
        logic cs_s;
        logic [3:0] io_s;
        logic wide;
        logic [31:0] sh_n;
        logic [5:0] cnt_n;
        logic [7:0] status;
        logic hw_reset;
        logic wr_boot;
        logic wr_live;
        sclk_s = pins[5];
        cs_s = pins[4];
        io_s = pins[3:0];
        wide = state_ff.live[flnvc_pkg::BIT_WIDE_INSTRUCTION];
        sh_n = wide ? {state_ff.sh[27:0], io_s} : {state_ff.sh[30:0], io_s[0]};
        cnt_n = state_ff.cnt + (wide ? flnvc_pkg::STEP_WIDE : flnvc_pkg::STEP_SERIAL);
        status = 8'h00;
        status[flnvc_pkg::BIT_STATUS_BUSY] = state_ff.busy; // R9
        status[flnvc_pkg::BIT_STATUS_WEL] = state_ff.wel;
        hw_reset = state_ff.live[flnvc_pkg::BIT_IO3_RESET] && !io_s[3] && !state_ff.oe[3]
            && state_ff.drv_hist == 4'h0 && (cs_s || !i_quad_mode || !wide); // R2
        wr_boot = 1'b0;
        wr_live = 1'b0;
        nxt_state = state_ff;
        nxt_state.sclk_prev = sclk_s;
        nxt_state.cs_prev = cs_s;
        nxt_state.drv_hist = {state_ff.drv_hist[2:0], state_ff.oe[3]};

        if (state_ff.busy) begin
            if (state_ff.prog_cnt == 16'h0000) begin
                nxt_state.busy = 1'b0;
                nxt_state.wel = 1'b0;
                nxt_state.boot = state_ff.pend;
                nxt_state.live[flnvc_pkg::BIT_ADDRESS_LIVE] =
                    state_ff.pend[flnvc_pkg::BIT_ADDRESS_BOOT]; // R16
                nxt_state.live[flnvc_pkg::BIT_ADDRESS_BOOT] =
                    state_ff.pend[flnvc_pkg::BIT_ADDRESS_BOOT]; // R16
            end else begin
                nxt_state.prog_cnt = state_ff.prog_cnt - 16'h0001; // R17
            end
        end

        if (cs_s) begin
            nxt_state.phase = flnvc_pkg::PH_IDLE;
            nxt_state.oe = 4'h0;
        end else if (state_ff.cs_prev) begin
            nxt_state.phase = flnvc_pkg::PH_CMD;
            nxt_state.cnt = 6'h00;
            nxt_state.got = 1'b0;
            nxt_state.nbytes = 2'h0;
        end else if (sclk_s && !state_ff.sclk_prev && state_ff.phase != flnvc_pkg::PH_RDATA
                     && state_ff.phase != flnvc_pkg::PH_IDLE) begin
            nxt_state.sh = sh_n;
            nxt_state.cnt = cnt_n;
            unique case (state_ff.phase)
                flnvc_pkg::PH_CMD: begin
                    if (cnt_n == flnvc_pkg::BITS_BYTE) begin
                        nxt_state.cmd = sh_n[7:0];
                        nxt_state.cnt = 6'h00;
                        unique case (sh_n[7:0])
                            flnvc_pkg::CMD_READ_ANY_REGISTER,
                            flnvc_pkg::CMD_WRITE_ANY_REGISTER: begin
                                nxt_state.phase = flnvc_pkg::PH_ADDR; // R1
                            end
                            flnvc_pkg::CMD_WRITE_REGISTERS: begin
                                nxt_state.phase = flnvc_pkg::PH_WDATA; // R1
                            end
                            flnvc_pkg::CMD_READ_STATUS: begin
                                nxt_state.phase = flnvc_pkg::PH_RDATA; // R9
                                nxt_state.rdata = status;
                            end
                            default: begin
                                nxt_state.phase = flnvc_pkg::PH_SKIP;
                            end
                        endcase
                    end
                end
                flnvc_pkg::PH_ADDR: begin
                    if (cnt_n == (state_ff.live[flnvc_pkg::BIT_ADDRESS_LIVE]
                        ? flnvc_pkg::BITS_ADDR_LONG : flnvc_pkg::BITS_ADDR_SHORT)) begin // R14
                        nxt_state.addr = sh_n[23:0];
                        nxt_state.cnt = 6'h00;
                        if (state_ff.cmd == flnvc_pkg::CMD_READ_ANY_REGISTER) begin
                            nxt_state.phase = flnvc_pkg::PH_RDATA;
                            if (sh_n[23:0] == flnvc_pkg::ADDR_BOOT_INTERFACE_CONFIG) begin
                                nxt_state.rdata = state_ff.boot; // R1
                            end else if (sh_n[23:0] == flnvc_pkg::ADDR_LIVE_INTERFACE_CONFIG) begin
                                nxt_state.rdata = state_ff.live;
                            end else if (sh_n[23:0] == flnvc_pkg::ADDR_LIVE_STATUS_ONE) begin
                                nxt_state.rdata = status;
                            end else begin
                                nxt_state.rdata = 8'h00;
                            end
                        end else begin
                            nxt_state.phase = flnvc_pkg::PH_WDATA;
                        end
                    end
                end
                flnvc_pkg::PH_WDATA: begin
                    if (cnt_n == flnvc_pkg::BITS_BYTE) begin
                        nxt_state.cnt = 6'h00;
                        if ((state_ff.cmd == flnvc_pkg::CMD_WRITE_ANY_REGISTER
                             && state_ff.nbytes == 2'h0)
                            || (state_ff.cmd == flnvc_pkg::CMD_WRITE_REGISTERS
                                && state_ff.nbytes == 2'h2)) begin
                            nxt_state.wdata = sh_n[7:0];
                            nxt_state.got = 1'b1;
                        end
                        if (state_ff.nbytes != 2'h3) begin
                            nxt_state.nbytes = state_ff.nbytes + 2'h1;
                        end
                    end
                end
                flnvc_pkg::PH_SKIP: nxt_state.cnt = cnt_n;
                default: begin
                    nxt_state.phase = flnvc_pkg::PH_IDLE;
                end
            endcase
        end else if (!sclk_s && state_ff.sclk_prev && state_ff.phase == flnvc_pkg::PH_RDATA) begin
            if (wide) begin
                nxt_state.out = state_ff.rdata[7:4];
                nxt_state.oe = 4'hF;
                nxt_state.rdata = {state_ff.rdata[3:0], state_ff.rdata[7:4]};
            end else begin
                nxt_state.out = {2'b00, state_ff.rdata[7], 1'b0};
                nxt_state.oe = 4'h2;
                nxt_state.rdata = {state_ff.rdata[6:0], state_ff.rdata[7]};
            end
        end

        // commands act when chip select rises after a whole frame
        if (cs_s && !state_ff.cs_prev && !state_ff.busy) begin // R17
            if (state_ff.phase == flnvc_pkg::PH_SKIP && state_ff.cnt == 6'h00) begin
                nxt_state.rst_en = state_ff.cmd == flnvc_pkg::CMD_RESET_ENABLE;
                unique case (state_ff.cmd)
                    flnvc_pkg::CMD_NV_WRITE_ENABLE: nxt_state.wel = 1'b1; // R1
                    flnvc_pkg::CMD_VOL_WRITE_ENABLE: nxt_state.wvel = 1'b1;
                    flnvc_pkg::CMD_ENTER_WIDE_INSTRUCTION: begin
                        nxt_state.live[flnvc_pkg::BIT_WIDE_INSTRUCTION] = 1'b1; // R7
                    end
                    flnvc_pkg::CMD_EXIT_WIDE_INSTRUCTION: begin
                        nxt_state.live[flnvc_pkg::BIT_WIDE_INSTRUCTION] = 1'b0; // R10
                    end
                    default: nxt_state.rst_en = nxt_state.rst_en;
                endcase
                if (state_ff.cmd == flnvc_pkg::CMD_SOFT_RESET && state_ff.rst_en) begin
                    nxt_state.live = load_live(state_ff.boot); // R3 R6 R12
                    nxt_state.wel = 1'b0;
                    nxt_state.wvel = 1'b0;
                end
            end else if (state_ff.phase == flnvc_pkg::PH_WDATA && state_ff.got
                         && state_ff.cnt == 6'h00) begin
                if (state_ff.cmd == flnvc_pkg::CMD_WRITE_REGISTERS) begin
                    wr_boot = state_ff.wel; // R1
                    wr_live = state_ff.wvel && !state_ff.wel;
                end else begin
                    wr_boot = state_ff.wel
                        && state_ff.addr == flnvc_pkg::ADDR_BOOT_INTERFACE_CONFIG; // R1
                    wr_live = (state_ff.wel || state_ff.wvel)
                        && state_ff.addr == flnvc_pkg::ADDR_LIVE_INTERFACE_CONFIG;
                end
                if (wr_boot) begin
                    nxt_state.pend = state_ff.wdata & flnvc_pkg::BOOT_CONFIG_WRITABLE; // R15
                    nxt_state.busy = 1'b1; // R17
                    nxt_state.prog_cnt = 16'(PROG_CYCLES - 1);
                end else begin
                    nxt_state.wel = 1'b0;
                end
                if (wr_live) begin
                    nxt_state.live = (state_ff.wdata & flnvc_pkg::LIVE_CONFIG_WRITABLE)
                        | (state_ff.live & ~flnvc_pkg::LIVE_CONFIG_WRITABLE); // R8
                end
                nxt_state.wvel = 1'b0;
            end
        end

        if (hw_reset) begin
            nxt_state.live = load_live(state_ff.boot); // R3 R6 R12
            nxt_state.phase = flnvc_pkg::PH_IDLE;
            nxt_state.oe = 4'h0;
            nxt_state.wel = state_ff.busy;
            nxt_state.wvel = 1'b0;
            nxt_state.rst_en = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_ff <= ST_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_io = state_ff.out;
    assign o_io_oe = state_ff.oe;
    assign o_io3_reset_enable = state_ff.live[flnvc_pkg::BIT_IO3_RESET]; // R2
    assign o_drive_strength = state_ff.live[flnvc_pkg::BIT_DRIVE_HI:flnvc_pkg::BIT_DRIVE_LO]; // R4
    assign o_four_wide_instruction_mode = state_ff.live[flnvc_pkg::BIT_WIDE_INSTRUCTION]; // R5
    assign o_protect_method = state_ff.live[flnvc_pkg::BIT_PROTECT_METHOD]; // R11
    assign o_address_four_byte = state_ff.live[flnvc_pkg::BIT_ADDRESS_LIVE]; // R13
    assign o_busy = state_ff.busy;
    assign o_boot_interface_config = state_ff.boot;
endmodule
`default_nettype wire

// *** rtl/flnvc_pkg.sv ***
package flnvc_pkg;

    // command codes
    localparam logic [7:0] CMD_NV_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_VOL_WRITE_ENABLE = 8'h50;
    localparam logic [7:0] CMD_WRITE_REGISTERS = 8'h01;
    localparam logic [7:0] CMD_READ_ANY_REGISTER = 8'h65;
    localparam logic [7:0] CMD_WRITE_ANY_REGISTER = 8'h71;
    localparam logic [7:0] CMD_ENTER_WIDE_INSTRUCTION = 8'h38;
    localparam logic [7:0] CMD_EXIT_WIDE_INSTRUCTION = 8'hF5;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
    localparam logic [7:0] CMD_SOFT_RESET = 8'h99;

    // register addresses inside the any-register space
    localparam logic [23:0] ADDR_LIVE_STATUS_ONE = 24'h800000;
    localparam logic [23:0] ADDR_BOOT_INTERFACE_CONFIG = 24'h000003;
    localparam logic [23:0] ADDR_LIVE_INTERFACE_CONFIG = 24'h800003;

    // field positions of the interface configuration registers
    localparam int unsigned BIT_IO3_RESET = 7;
    localparam int unsigned BIT_DRIVE_HI = 6;
    localparam int unsigned BIT_DRIVE_LO = 5;
    localparam int unsigned BIT_RESERVED_HI = 4;
    localparam int unsigned BIT_WIDE_INSTRUCTION = 3;
    localparam int unsigned BIT_PROTECT_METHOD = 2;
    localparam int unsigned BIT_ADDRESS_BOOT = 1;
    localparam int unsigned BIT_ADDRESS_LIVE = 0;

    // status field positions
    localparam int unsigned BIT_STATUS_BUSY = 0;
    localparam int unsigned BIT_STATUS_WEL = 1;

    // reset value and writable masks
    localparam logic [7:0] BOOT_CONFIG_RESET = 8'h60;
    localparam logic [7:0] BOOT_CONFIG_WRITABLE = 8'hEE;
    localparam logic [7:0] LIVE_CONFIG_WRITABLE = 8'hED;

    // frame bit counts
    localparam logic [5:0] BITS_BYTE = 6'h08;
    localparam logic [5:0] BITS_ADDR_SHORT = 6'h18;
    localparam logic [5:0] BITS_ADDR_LONG = 6'h20;
    localparam logic [5:0] STEP_SERIAL = 6'h01;
    localparam logic [5:0] STEP_WIDE = 6'h04;

    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PROG_TIME_NS = 100000;
    localparam int PROG_CYCLES = (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_CMD = 3'b001,
        PH_ADDR = 3'b010,
        PH_WDATA = 3'b011,
        PH_RDATA = 3'b100,
        PH_SKIP = 3'b101
    } flnvc_phase_type;

endpackage

// *** rtl/flnvc_pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module flnvc_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // pins
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } flnvc_sync_type;

    flnvc_sync_type sync_ff;
    flnvc_sync_type nxt_sync;

    always_comb begin
        nxt_sync = sync_ff;
        nxt_sync.s1 = i_async;
        nxt_sync.s2 = sync_ff.s1;
        nxt_sync.s3 = sync_ff.s2;
        // a bit changes once the second and third stages agree
        for (int i = 0; i < W; i++) begin
            if (sync_ff.s2[i] == sync_ff.s3[i]) begin
                nxt_sync.lvl[i] = sync_ff.s3[i];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sync_ff <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL};
        end else begin
            sync_ff <= nxt_sync;
        end
    end

    assign o_level = sync_ff.lvl;
endmodule
`default_nettype wire

// *** testbench/flnvc_boot_config_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module flnvc_boot_config_checker #(
    parameter int PROG_CYCLES = 20
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // link pins
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic [3:0] i_io,
    input wire logic [3:0] o_io,
    input wire logic [3:0] o_io_oe,
    // configuration
    input wire logic i_quad_mode,
    input wire logic o_io3_reset_enable,
    input wire logic [1:0] o_drive_strength,
    input wire logic o_four_wide_instruction_mode,
    input wire logic o_protect_method,
    input wire logic o_address_four_byte,
    input wire logic o_busy,
    input wire logic [7:0] o_boot_interface_config
);
    typedef struct packed {
        logic [31:0] busy_cnt;
        logic [3:0] low_cnt;
    } flnvc_chk_state_type;
    flnvc_chk_state_type state_ff;
    flnvc_chk_state_type nxt_state;
    // cycles busy; cycles io3 low with chip select high
    always_comb begin
        nxt_state.busy_cnt = o_busy ? state_ff.busy_cnt + 32'h1 : 32'h0;
        nxt_state.low_cnt = (!i_io[3] && i_cs_n) ?
            state_ff.low_cnt + {3'h0, state_ff.low_cnt != 4'hF} : 4'h0;
        if (i_rst) begin
            nxt_state = '0;
        end
    end
    always_ff @(posedge i_clk) begin
        state_ff <= nxt_state;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_busy_run;
        o_busy [*8];
    endsequence
    sequence s_live_from_boot;
        o_four_wide_instruction_mode == o_boot_interface_config[3] &&
        o_protect_method == o_boot_interface_config[2] &&
        o_drive_strength == o_boot_interface_config[6:5];
    endsequence
    a_reset_boot_value: assert property (
        $fell(i_rst) |-> o_boot_interface_config == 8'h60)
        else $error("boot register wrong after reset");
    a_reset_live_value: assert property (
        $fell(i_rst) |-> o_drive_strength == 2'b11 && !o_io3_reset_enable && !o_busy &&
        !o_four_wide_instruction_mode && !o_protect_method && !o_address_four_byte)
        else $error("live outputs wrong after reset");
    a_reserved_bits_zero: assert property (
        o_boot_interface_config[4] == 1'b0 && o_boot_interface_config[0] == 1'b0)
        else $error("reserved boot bit set");
    a_boot_needs_busy: assert property (
        $changed(o_boot_interface_config) |-> $past(o_busy))
        else $error("boot register changed without programming");
    a_addr_len_follows: assert property (
        $changed(o_boot_interface_config[1]) |->
        ##[0:2] o_address_four_byte == o_boot_interface_config[1])
        else $error("address length not updated with boot bit");
    a_busy_time_bound: assert property (
        state_ff.busy_cnt <= 32'(PROG_CYCLES + 2))
        else $error("busy held too long");
    a_busy_holds_min: assert property (
        $rose(o_busy) |-> s_busy_run)
        else $error("busy dropped early");
    a_hw_reset_reload: assert property (
        state_ff.low_cnt == 4'hA && o_io3_reset_enable |-> ##[1:4] s_live_from_boot)
        else $error("hardware reset did not reload live config");
    a_oe_width_mode: assert property (
        o_io_oe != 4'h0 |-> o_io_oe == (o_four_wide_instruction_mode ? 4'hF : 4'h2))
        else $error("output enable width wrong");
endmodule
bind flnvc_boot_config flnvc_boot_config_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_io(i_io),
    .o_io(o_io), .o_io_oe(o_io_oe), .i_quad_mode(i_quad_mode),
    .o_io3_reset_enable(o_io3_reset_enable), .o_drive_strength(o_drive_strength),
    .o_four_wide_instruction_mode(o_four_wide_instruction_mode),
    .o_protect_method(o_protect_method), .o_address_four_byte(o_address_four_byte),
    .o_busy(o_busy), .o_boot_interface_config(o_boot_interface_config));
`default_nettype wire

// *** testbench/flnvc_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module flnvc_host_model (
    // clock
    input wire logic i_clk,
    // link pins
    input wire logic [3:0] i_io,
    output logic o_sclk,
    output logic o_cs_n,
    output logic [3:0] o_io
);
    logic wide;
    logic four_byte;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_io = 4'hF;
        wide = 1'b0;
        four_byte = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // one frame msb first; link clock still and lines pulled up between frames
    task automatic xfer(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
        int step;
        step = wide ? 4 : 1;
        rx = '0;
        o_cs_n = 1'b0;
        for (int i = nbits - step; i >= 0; i -= step) begin
            o_io = wide ? 4'(tx >> i) : {3'h7, tx[i]};
            tick(8);
            o_sclk = 1'b1;
            rx = wide ? {rx[59:0], i_io} : {rx[62:0], i_io[1]};
            tick(8);
            o_sclk = 1'b0;
        end
        tick(8);
        o_cs_n = 1'b1;
        o_io = 4'hF;
        tick(40);
    endtask
    task automatic cmd(input logic [7:0] c);
        logic [63:0] rx;
        xfer({56'h0, c}, 8, rx);
    endtask
    function automatic logic [63:0] frame(input logic [7:0] c, input logic [7:0] v);
        return four_byte ? {16'h0, c, 8'h00, flnvc_pkg::ADDR_BOOT_INTERFACE_CONFIG, v}
            : {24'h0, c, flnvc_pkg::ADDR_BOOT_INTERFACE_CONFIG, v};
    endfunction
    task automatic wr(input logic [7:0] v, input logic en);
        logic [63:0] rx;
        if (en) begin
            cmd(flnvc_pkg::CMD_NV_WRITE_ENABLE);
        end
        xfer(frame(flnvc_pkg::CMD_WRITE_ANY_REGISTER, v), four_byte ? 48 : 40, rx);
    endtask
    task automatic write_registers_cmd(input logic [7:0] v);
        logic [63:0] rx;
        cmd(flnvc_pkg::CMD_NV_WRITE_ENABLE);
        xfer({32'h0, flnvc_pkg::CMD_WRITE_REGISTERS, 16'h0000, v}, 32, rx);
    endtask
    task automatic rd(output logic [7:0] v);
        logic [63:0] rx;
        xfer(frame(flnvc_pkg::CMD_READ_ANY_REGISTER, 8'h00), four_byte ? 48 : 40, rx);
        v = rx[7:0];
    endtask
    task automatic poll(output logic ok);
        logic [63:0] rx;
        ok = 1'b0;
        for (int i = 0; i < 20 && !ok; i++) begin
            xfer({48'h0, flnvc_pkg::CMD_READ_STATUS, 8'h00}, 16, rx);
            ok = rx[flnvc_pkg::BIT_STATUS_BUSY] === 1'b0;
        end
    endtask
    task automatic soft_reset();
        cmd(flnvc_pkg::CMD_RESET_ENABLE);
        cmd(flnvc_pkg::CMD_SOFT_RESET);
    endtask
    task automatic io3_pulse();
        o_io[3] = 1'b0;
        tick(16);
        o_io[3] = 1'b1;
        tick(16);
    endtask
endmodule
`default_nettype wire

// *** testbench/flnvc_boot_config_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module flnvc_boot_config_test;
    logic clk;
    logic rst;
    logic quad;
    logic sclk;
    logic cs_n;
    logic [3:0] host_io;
    logic [3:0] dut_io;
    logic [3:0] dut_oe;
    logic [3:0] pin;
    logic io3_en;
    logic [1:0] drive;
    logic wide;
    logic prot;
    logic four;
    logic busy;
    logic [7:0] boot;
    logic [7:0] d;
    logic [7:0] rd;
    logic [31:0] seed;
    logic ok;
    int fail_count = 0;
    int check_count = 0;
    assign pin = (dut_oe & dut_io) | (~dut_oe & host_io);
    flnvc_boot_config #(.PROG_CYCLES(2000)) u_dut (
        .i_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_io(pin),
        .o_io(dut_io), .o_io_oe(dut_oe), .i_quad_mode(quad), .o_io3_reset_enable(io3_en),
        .o_drive_strength(drive), .o_four_wide_instruction_mode(wide),
        .o_protect_method(prot), .o_address_four_byte(four), .o_busy(busy),
        .o_boot_interface_config(boot));
    flnvc_host_model u_host (
        .i_clk(clk), .i_io(pin), .o_sclk(sclk), .o_cs_n(cs_n), .o_io(host_io));
    always #2.5 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] f_boot(input logic [7:0] v);
        return {v[7:5], 1'b0, v[3:1], 1'b0};
    endfunction
    function automatic logic [7:0] live();
        return {io3_en, drive, 1'b0, wide, prot, four, 1'b0};
    endfunction
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clk);
        fail_count++;
        results();
    end
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        quad = 1'b1;
        seed = 32'h9D7AEE81;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        u_host.tick(8);
        chk("boot", 8'h60, boot);
        chk("live", 8'h60, live());
        u_host.rd(rd);
        chk("read boot", 8'h60, rd);
        $display("test defaults done");
        u_host.wr(8'h0C, 1'b0);
        chk("boot no enable", 8'h60, boot);
        u_host.wr(8'h84, 1'b1);
        u_host.wr(8'h0C, 1'b1);
        chk("busy", 8'h01, {7'h0, busy});
        u_host.poll(ok);
        chk("boot while busy", 8'h84, boot);
        $display("test refusals done");
        quad = 1'b0;
        u_host.cmd(flnvc_pkg::CMD_ENTER_WIDE_INSTRUCTION);
        u_host.wide = 1'b1;
        u_host.io3_pulse();
        chk("wide io3 off", 8'h01, {7'h0, wide});
        u_host.cmd(flnvc_pkg::CMD_EXIT_WIDE_INSTRUCTION);
        u_host.wide = 1'b0;
        chk("wide exit", 8'h00, {7'h0, wide});
        u_host.soft_reset();
        chk("live soft", 8'h84, live());
        u_host.cmd(flnvc_pkg::CMD_ENTER_WIDE_INSTRUCTION);
        chk("wide enter", 8'h01, {7'h0, wide});
        u_host.io3_pulse();
        chk("live hard", 8'h84, live());
        quad = 1'b1;
        $display("test resets done");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            d = (i == 0) ? 8'hFF : (i == 7) ? 8'h00 : seed[7:0];
            u_host.wr(d, 1'b1);
            u_host.poll(ok);
            chk("poll", 8'h01, {7'h0, ok});
            chk("boot", f_boot(d), boot);
            chk("addr len", {7'h0, d[1]}, {7'h0, four});
            u_host.four_byte = d[1];
            u_host.rd(rd);
            chk("read boot", f_boot(d), rd);
            u_host.soft_reset();
            u_host.wide = d[3];
            chk("live", f_boot(d), live());
        end
        $display("test random writes done");
        u_host.write_registers_cmd(8'h24);
        u_host.poll(ok);
        chk("poll", 8'h01, {7'h0, ok});
        chk("write regs", 8'h24, boot);
        $display("test write registers done");
        results();
    end
endmodule
`default_nettype wire
